// ==== hdl/lsc_lane_status.sv ====
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// (R1) Checksum bit per lane, bit equals lane
// (R2) Checksum bit 1 correct, 0 incorrect
// (R3) Sync bits per lane at 0x473
// (R4) Sync bit 1 achieved, 0 lost
// (R5) Link page at 0x300 selects shown link
// (R6) Checksum register 0x472 covers lanes 7-0
// (R7) Sync register covers lanes 7-0
// (R8) Status resets to zero, writes ignored
module lsc_lane_status
	import lsc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [LSC_LINKS*LSC_LANES-1:0] lane_checksum_ok,
	input wire logic [LSC_LINKS*LSC_LANES-1:0] lane_initial_synced,
	input wire logic [LSC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [LSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	logic [LSC_LANES-1:0] chk_r [LSC_LINKS];
	logic [LSC_LANES-1:0] ils_r [LSC_LINKS];
	logic [LSC_IRQ_W-1:0] evt;
	logic link_page_r;
	logic [LSC_IRQ_W-1:0] irq_status_r;
	logic [LSC_IRQ_W-1:0] irq_status_nxt;
	logic [LSC_IRQ_W-1:0] irq_enable_r;
	logic [LSC_IRQ_W-1:0] irq_clear;
	logic aw_held_r;
	logic w_held_r;
	logic [11:0] waddr_idx_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic do_write;
	logic wr_mapped;
	logic wr_fire;
	logic page_we;
	logic enable_we;
	logic clear_we;
	logic [11:0] rd_idx;
	logic [31:0] rdata_nxt;
	logic rd_mapped;

	// One status pair per link; the page only steers the read mux
	genvar gl;
	generate
		for (gl = 0; gl < LSC_LINKS; gl++) begin : g_link
			lsc_link_status u_link (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.checksum_ok_in(lane_checksum_ok[gl*LSC_LANES +: LSC_LANES]),
				.initial_synced_in(lane_initial_synced[gl*LSC_LANES +: LSC_LANES]),
				.checksum_ok_r(chk_r[gl]),
				.initial_synced_r(ils_r[gl]),
				.sync_lost_evt_r(evt[2*gl+LSC_EVT_SYNC_LOST]),
				.checksum_bad_evt_r(evt[2*gl+LSC_EVT_CHK_BAD])
			);
		end
	endgenerate

	// Write channel: address and data taken in either order
	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	// Only strobe bit 0 matters: every register fits in byte 0
	assign wr_fire = do_write && wstrb0_r;
	assign page_we = wr_fire && (waddr_idx_r == LSC_IDX_LINK_PAGE);
	assign enable_we = wr_fire && (waddr_idx_r == LSC_IDX_IRQ_ENABLE);
	assign clear_we = wr_fire && (waddr_idx_r == LSC_IDX_IRQ_CLEAR);

	// Status indices answer OKAY but have no write path
	always_comb begin
		case (waddr_idx_r)
			LSC_IDX_LINK_PAGE, LSC_IDX_CHECKSUM, LSC_IDX_INIT_SYNC: wr_mapped = 1'b1;
			LSC_IDX_IRQ_STATUS, LSC_IDX_IRQ_ENABLE, LSC_IDX_IRQ_CLEAR: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// Ready stays low until the response is taken: one write at a time

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			s_axi_awready <= 1'b1;
			waddr_idx_r <= 12'h000;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				s_axi_awready <= 1'b0;
				waddr_idx_r <= s_axi_awaddr[LSC_ADDR_W-1:2];
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			s_axi_wready <= 1'b1;
			wdata_r <= 32'h00000000;
			wstrb0_r <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Unmapped index answers SLVERR and changes nothing

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= LSC_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software picks the link before reading lane status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_page_r <= LSC_PAGE_RST;
		end else if (ce && page_we) begin
			link_page_r <= wdata_r[LSC_PAGE_POS]; // R5
		end
	end

	// Enable is plain read-write, same layout as status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_r <= LSC_IRQ_RST;
		end else if (ce && enable_we) begin
			irq_enable_r <= wdata_r[LSC_IRQ_W-1:0];
		end
	end

	// Clear is write-one; a same-cycle event beats the clear
	assign irq_clear = clear_we ? wdata_r[LSC_IRQ_W-1:0] : LSC_IRQ_RST;
	assign irq_status_nxt = (irq_status_r & ~irq_clear) | evt;

	// Irq built from next status so it never lags the sticky bits

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= LSC_IRQ_RST;
			irq <= 1'b0;
		end else if (ce) begin
			irq_status_r <= irq_status_nxt;
			irq <= |(irq_status_nxt & irq_enable_r);
		end
	end

	// Read decode; status registers have no write path at all
	assign rd_idx = s_axi_araddr[LSC_ADDR_W-1:2];

	always_comb begin
		rdata_nxt = 32'h00000000;
		rd_mapped = 1'b1;
		case (rd_idx)
			LSC_IDX_LINK_PAGE: rdata_nxt[LSC_PAGE_POS] = link_page_r; // R5
			LSC_IDX_CHECKSUM: rdata_nxt[LSC_LANES-1:0] = chk_r[link_page_r]; // R1 R5 R6 R8
			LSC_IDX_INIT_SYNC: rdata_nxt[LSC_LANES-1:0] = ils_r[link_page_r]; // R3 R5 R7 R8
			LSC_IDX_IRQ_STATUS: rdata_nxt[LSC_IRQ_W-1:0] = irq_status_r;
			LSC_IDX_IRQ_ENABLE: rdata_nxt[LSC_IRQ_W-1:0] = irq_enable_r;
			LSC_IDX_IRQ_CLEAR: rdata_nxt = 32'h00000000;
			default: rd_mapped = 1'b0;
		endcase
	end

	// Answer one cycle after the address is taken

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= LSC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_nxt;
				s_axi_rresp <= rd_mapped ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : lsc_lane_status

// ==== hdl/lsc_pkg.sv ====
package lsc_pkg;
	localparam int LSC_LANES = 8;
	localparam int LSC_LINKS = 2;
	localparam int LSC_ADDR_W = 14;
	localparam int LSC_IRQ_W = 2 * LSC_LINKS;
	// Register indices; byte address is four times the index
	localparam logic [11:0] LSC_IDX_LINK_PAGE = 12'h300;
	localparam logic [11:0] LSC_IDX_CHECKSUM = 12'h472;
	localparam logic [11:0] LSC_IDX_INIT_SYNC = 12'h473;
	localparam logic [11:0] LSC_IDX_IRQ_STATUS = 12'h480;
	localparam logic [11:0] LSC_IDX_IRQ_ENABLE = 12'h481;
	localparam logic [11:0] LSC_IDX_IRQ_CLEAR = 12'h482;
	// Field layout
	localparam int LSC_PAGE_POS = 0;
	localparam int LSC_EVT_SYNC_LOST = 0;
	localparam int LSC_EVT_CHK_BAD = 1;
	// Reset values
	localparam logic [7:0] LSC_STATUS_RST = 8'h00;
	localparam logic LSC_PAGE_RST = 1'h0;
	localparam logic [LSC_IRQ_W-1:0] LSC_IRQ_RST = 4'h0;
	// AXI responses
	localparam logic [1:0] LSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] LSC_RESP_SLVERR = 2'h2;
endpackage : lsc_pkg

// ==== hdl/lsc_link_status.sv ====
`timescale 1ns/1ps
module lsc_link_status
	import lsc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [LSC_LANES-1:0] checksum_ok_in,
	input wire logic [LSC_LANES-1:0] initial_synced_in,
	output logic [LSC_LANES-1:0] checksum_ok_r,
	output logic [LSC_LANES-1:0] initial_synced_r,
	output logic sync_lost_evt_r,
	output logic checksum_bad_evt_r
);
	logic [LSC_LANES-1:0] checksum_ok_nxt;
	logic [LSC_LANES-1:0] initial_synced_nxt;

	// Bit position equals lane number, 1 means good/achieved
	assign checksum_ok_nxt = checksum_ok_in; // R1 R2 R6
	assign initial_synced_nxt = initial_synced_in; // R3 R4 R7

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			checksum_ok_r <= LSC_STATUS_RST; // R8
			initial_synced_r <= LSC_STATUS_RST; // R8
		end else if (ce) begin
			checksum_ok_r <= checksum_ok_nxt;
			initial_synced_r <= initial_synced_nxt;
		end
	end

	// A lane dropping from good to bad is the event, not the level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_lost_evt_r <= 1'b0;
			checksum_bad_evt_r <= 1'b0;
		end else if (ce) begin
			sync_lost_evt_r <= |(initial_synced_r & ~initial_synced_nxt);
			checksum_bad_evt_r <= |(checksum_ok_r & ~checksum_ok_nxt);
		end
	end
endmodule : lsc_link_status

// ==== sim/lsc_tx_model.sv ====
`timescale 1ns/1ps
module lsc_tx_model (
	input wire logic aclk,
	input wire logic [15:0] ck_w,
	input wire logic [15:0] sy_w,
	output logic [15:0] ck_r = 16'h0,
	output logic [15:0] sy_r = 16'h0
);
	// One edge late, like a real far end
	always @(posedge aclk) begin
		ck_r <= ck_w;
		sy_r <= sy_w;
	end
endmodule : lsc_tx_model

// ==== sim/lsc_lane_status_props.sv ====
`timescale 1ns/1ps
module lsc_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_rst_quiet: assert property ($rose(aresetn) |-> !(s_axi_bvalid || s_axi_rvalid || irq))
		else $error("busy after reset");
	a_wr_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write answer");
	a_b_done: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready && s_axi_wready) else $error("write not closed");
	a_rd_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	a_r_done: assert property (ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
		&& s_axi_arready) else $error("read not closed");
	a_rd_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper bits set");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar open in read");
	a_aw_busy: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
		else $error("aw open in write");
endmodule : lsc_props
bind lsc_lane_status lsc_props lsc_props_inst (.aclk, .aresetn, .ce, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq);

// ==== sim/lsc_lane_status_tb.sv ====
`timescale 1ns/1ps
module lsc_lane_status_tb
	import lsc_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, irq;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] lane_checksum_ok, lane_initial_synced, ck_w = 16'h0, sy_w = 16'h0;
	int checked = 0, n_mismatch = 0;
	lsc_tx_model lsc_tx_model_inst (.aclk, .ck_w, .sy_w, .ck_r(lane_checksum_ok),
		.sy_r(lane_initial_synced));
	lsc_lane_status lsc_lane_status_inst (.aclk, .aresetn, .ce, .lane_checksum_ok,
		.lane_initial_synced, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	initial forever #50 aclk = ~aclk;
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic hang(input int n);
		if (n >= 40) begin
			n_mismatch++;
			give_verdict();
		end
	endtask : hang
	task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		s_axi_bready <= 1'b0;
		hang(n);
		chk({30'h0, s_axi_bresp}, {30'h0, e});
	endtask : wr
	task automatic rd(input logic [11:0] i, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		s_axi_rready <= 1'b0;
		hang(n);
		chk(s_axi_rdata, d);
		chk({30'h0, s_axi_rresp}, {30'h0, e});
	endtask : rd
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(LSC_IDX_CHECKSUM, 32'h0, LSC_RESP_OKAY);
		rd(LSC_IDX_INIT_SYNC, 32'h0, LSC_RESP_OKAY);
		$display("reset test done");
		// No mirror-image patterns, so a swapped lane order shows
		ck_w <= 16'h6A17;
		sy_w <= 16'hD31C;
		repeat (3) @(posedge aclk);
		rd(LSC_IDX_CHECKSUM, 32'h17, LSC_RESP_OKAY);
		rd(LSC_IDX_INIT_SYNC, 32'h1C, LSC_RESP_OKAY);
		wr(LSC_IDX_LINK_PAGE, 32'h1, LSC_RESP_OKAY);
		rd(LSC_IDX_CHECKSUM, 32'h6A, LSC_RESP_OKAY);
		rd(LSC_IDX_INIT_SYNC, 32'hD3, LSC_RESP_OKAY);
		wr(LSC_IDX_CHECKSUM, 32'hFF, LSC_RESP_OKAY);
		rd(LSC_IDX_CHECKSUM, 32'h6A, LSC_RESP_OKAY);
		rd(12'h001, 32'h0, LSC_RESP_SLVERR);
		wr(12'h001, 32'h1, LSC_RESP_SLVERR);
		$display("paging test done");
		// Sync drop on link 0, checksum going bad on link 1
		ck_w <= 16'h6817;
		sy_w <= 16'hD318;
		repeat (4) @(posedge aclk);
		rd(LSC_IDX_IRQ_STATUS, 32'h9, LSC_RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(LSC_IDX_IRQ_ENABLE, 32'h8, LSC_RESP_OKAY);
		rd(LSC_IDX_IRQ_ENABLE, 32'h8, LSC_RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
		wr(LSC_IDX_IRQ_CLEAR, 32'h9, LSC_RESP_OKAY);
		rd(LSC_IDX_IRQ_STATUS, 32'h0, LSC_RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		$display("irq test done");
		// Glitch while frozen must leave no trace
		ce <= 1'b0;
		sy_w <= 16'hD218;
		repeat (3) @(posedge aclk);
		sy_w <= 16'hD318;
		repeat (3) @(posedge aclk);
		ce <= 1'b1;
		rd(LSC_IDX_IRQ_STATUS, 32'h0, LSC_RESP_OKAY);
		rd(LSC_IDX_INIT_SYNC, 32'hD3, LSC_RESP_OKAY);
		$display("enable test done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(LSC_IDX_LINK_PAGE, 32'h0, LSC_RESP_OKAY);
		rd(LSC_IDX_CHECKSUM, 32'h17, LSC_RESP_OKAY);
		rd(LSC_IDX_IRQ_ENABLE, 32'h0, LSC_RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		$display("second reset test done");
		give_verdict();
	end
endmodule : lsc_lane_status_tb
